// [rtl/sre_pkg.sv]
// Shared constants and types for the serial EEPROM read engine and its bus master.
// Assumes both ends meet through sre_if and run from clk_in at 100 MHz.
//
// Overview of operation
// - Counter holds last accessed location plus one
// - Counter survives between transactions until power loss
// - Read increments wrap from top to zero
// - Write increments wrap inside the current page
// - Read address acked, byte at counter shifted out
// - Master ends single read with NACK, stop
// - Random read starts with address-only dummy write
// - Master repeats start after word address ack
// - Read address after repeated start returns loaded byte
// - Sequential read follows current or random read
// - Master acks each byte to continue
// - Master ack advances counter, next byte follows
// - Sequential read wraps past top without stopping
// - NACK then stop ends read, data released
// - 256 bytes, 32 pages of 8, 8-bit address
// - Device acks received words low on ninth clock
// - Ack own device address, otherwise back to standby
// - SDA fall/rise while SCL high: start/stop
package sre_pkg;
  localparam int ADDR_W = 8;
  localparam int PAGE_BITS = 3;
  localparam int MEM_BYTES = 256;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h50;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] KIND_CUR = 2'h0;
  localparam logic [1:0] KIND_RAND = 2'h1;
  localparam int CLK_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    SRE_D_IDLE = 3'h0,
    SRE_D_DEV = 3'h1,
    SRE_D_WAD = 3'h3,
    SRE_D_WDAT = 3'h2,
    SRE_D_RD = 3'h6
  } sre_dev_st_e;

  typedef enum logic [2:0] {
    SRE_H_IDLE = 3'h0,
    SRE_H_START = 3'h1,
    SRE_H_TX = 3'h3,
    SRE_H_RX = 3'h2,
    SRE_H_STOP = 3'h6
  } sre_host_st_e;
endpackage

// [rtl/sre_if.sv]
// Two-wire link between the EEPROM end and the bus master end.
// Both SDA drivers are open drain; the line resolves high when nobody pulls it.
`timescale 1ns/1ps
interface sre_if;
  logic scl;
  logic sda;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_host_o;
  logic sda_host_oe;

  // Pull-up modelled as the default high level
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));

  modport dev(input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host(output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface

// [rtl/sre_addr_ctr.sv]
// Word address counter of the EEPROM end.
// Assumes clk_in is the link clock; only power-up reset clears it.
`timescale 1ns/1ps
module sre_addr_ctr #(
  parameter int AW = sre_pkg::ADDR_W,
  parameter int PB = sre_pkg::PAGE_BITS
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic load_in,
  input wire logic [AW-1:0] load_val_in,
  input wire logic inc_in,
  input wire logic page_in,
  output logic [AW-1:0] addr_out
);
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] addr_next;
  logic [AW-1:0] addr_inc;
  logic [AW-1:0] addr_page;

  assign addr_inc = addr_reg + 1'b1;
  assign addr_page = {addr_reg[AW-1:PB], addr_inc[PB-1:0]};
  assign addr_next = load_in ? load_val_in :
                     !inc_in ? addr_reg :
                     page_in ? addr_page : addr_inc;
  assign addr_out = addr_reg;

  // Holds its value across frames; no protocol event clears it.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_reg <= AW'(sre_pkg::ADDR_RST);
    end else begin
      addr_reg <= addr_next;
    end
  end
endmodule

// [rtl/sre_dev.sv]
// EEPROM end of the two-wire link: address decode, word address load and reads.
// Assumes the master drives SCL and keeps SDA stable while SCL is high outside
// start and stop; the link logic runs on SCL itself, the load port on clk_in.
`timescale 1ns/1ps
module sre_dev #(
  parameter logic [6:0] DEV_ADDR = sre_pkg::DEV_ADDR_DFLT,
  parameter int AW = sre_pkg::ADDR_W,
  parameter int DEPTH = sre_pkg::MEM_BYTES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  sre_if.dev link,
  input wire logic ld_valid_in,
  input wire logic [AW-1:0] ld_addr_in,
  input wire logic [7:0] ld_data_in,
  output logic ld_ready_out,
  output logic busy_out
);
  // Array contents; preloaded from the user side while the link is idle.
  logic [7:0] mem [DEPTH];

  // Start and stop events, caught on the data line's own edges
  logic start_tog_reg;
  logic stop_tog_reg;
  logic start_seen_reg;
  logic stop_seen_reg;
  logic start_pend;
  logic stop_pend;

  // Link-side state, clocked by SCL
  sre_pkg::sre_dev_st_e st_reg;
  sre_pkg::sre_dev_st_e st_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] sh_shift;
  logic busy_reg;
  logic oe_reg;
  logic oe_next;

  // Counter control
  logic ctr_ld;
  logic ctr_inc;
  logic ctr_page;
  logic [AW-1:0] ctr_addr;

  // Decodes
  logic byte_done;
  logic dev_match;
  logic ack_due;
  logic tx_bit;
  logic drive_data;
  logic [7:0] rd_byte;

  // User-side view of the link state
  logic busy_s1_reg;
  logic busy_s2_reg;

  // SDA falling while SCL is high is a start.
  // The SCL level is looked at only at an SDA edge, where the protocol keeps
  // it settled, so no synchroniser is placed here.
  always_ff @(negedge link.sda or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_tog_reg <= 1'b0;
    end else if (link.scl) begin
      start_tog_reg <= ~start_tog_reg;
    end
  end

  // SDA rising while SCL is high is a stop.
  always_ff @(posedge link.sda or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stop_tog_reg <= 1'b0;
    end else if (link.scl) begin
      stop_tog_reg <= ~stop_tog_reg;
    end
  end

  // Toggles are compared with copies taken at every SCL rise; a start always
  // precedes the first rise of a frame by at least a hold time.
  assign start_pend = start_tog_reg ^ start_seen_reg;
  assign stop_pend = stop_tog_reg ^ stop_seen_reg;

  assign sh_shift = {sh_reg[6:0], link.sda};
  assign byte_done = (cnt_reg == sre_pkg::ACK_SLOT);
  assign dev_match = (sh_reg[7:1] == DEV_ADDR);

  // Next state, evaluated for the SCL rising edge
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ctr_ld = 1'b0;
    ctr_inc = 1'b0;
    ctr_page = 1'b0;
    if (start_pend) begin
      // First rise after a start carries the top address bit
      st_next = sre_pkg::SRE_D_DEV;
      cnt_next = 4'h1;
      sh_next = sh_shift;
    end else if (stop_pend) begin
      // Back to standby; nothing is driven until the next start.
      st_next = sre_pkg::SRE_D_IDLE;
      cnt_next = 4'h0;
    end else if (!byte_done) begin
      if (st_reg != sre_pkg::SRE_D_IDLE) begin
        cnt_next = cnt_reg + 4'h1;
      end
      if (st_reg != sre_pkg::SRE_D_RD) begin
        sh_next = sh_shift;
      end
    end else begin
      // Ninth clock of a word
      cnt_next = 4'h0;
      unique case (st_reg)
        sre_pkg::SRE_D_IDLE: begin
          st_next = sre_pkg::SRE_D_IDLE;
        end
        sre_pkg::SRE_D_DEV: begin
          if (!dev_match) begin
            st_next = sre_pkg::SRE_D_IDLE;
          end else if (sh_reg[0]) begin
            st_next = sre_pkg::SRE_D_RD;
          end else begin
            st_next = sre_pkg::SRE_D_WAD;
          end
        end
        sre_pkg::SRE_D_WAD: begin
          // Dummy write loads the counter; a read may follow.
          ctr_ld = 1'b1;
          st_next = sre_pkg::SRE_D_WDAT;
        end
        sre_pkg::SRE_D_WDAT: begin
          // Data bytes are acknowledged but not stored by this engine
          ctr_inc = 1'b1;
          ctr_page = 1'b1;
        end
        sre_pkg::SRE_D_RD: begin
          // The byte just sent counts as accessed, acked or not.
          ctr_inc = 1'b1;
          if (link.sda) begin
            st_next = sre_pkg::SRE_D_IDLE;
          end
        end
        default: begin
          st_next = sre_pkg::SRE_D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link.scl or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= sre_pkg::SRE_D_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      start_seen_reg <= start_tog_reg;
      stop_seen_reg <= stop_tog_reg;
      busy_reg <= (st_next != sre_pkg::SRE_D_IDLE);
    end
  end

  // Read counter; full-array wrap on reads keeps sequential reads running.
  sre_addr_ctr #(
    .AW(AW),
    .PB(sre_pkg::PAGE_BITS)
  ) u_ctr (
    .clk_in(link.scl),
    .arst_n_in(arst_n_in),
    .load_in(ctr_ld),
    .load_val_in(sh_reg[AW-1:0]),
    .inc_in(ctr_inc),
    .page_in(ctr_page),
    .addr_out(ctr_addr)
  );

  // Output side, changed on the SCL falling edge so SDA settles while low
  assign rd_byte = mem[ctr_addr];
  assign tx_bit = rd_byte[~cnt_reg[2:0]];
  assign ack_due = byte_done &&
                   (((st_reg == sre_pkg::SRE_D_DEV) && dev_match) ||
                    (st_reg == sre_pkg::SRE_D_WAD) ||
                    (st_reg == sre_pkg::SRE_D_WDAT));
  // Bits 0..7 of a read byte; slot 8 left to the master.
  assign drive_data = (st_reg == sre_pkg::SRE_D_RD) && !byte_done && !tx_bit;
  assign oe_next = ack_due | drive_data;

  always_ff @(negedge link.scl or negedge arst_n_in) begin
    if (!arst_n_in) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  // A stop drops the drive at once, since no further SCL edge may come.
  assign link.sda_dev_oe = oe_reg & ~stop_pend;
  assign link.sda_dev_o = 1'b0;

  // Busy level into the user clock domain
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
    end else begin
      busy_s1_reg <= busy_reg;
      busy_s2_reg <= busy_s1_reg;
    end
  end

  assign busy_out = busy_s2_reg;
  // Loading while a frame runs would race the link-side read path
  assign ld_ready_out = ~busy_s2_reg;

  always_ff @(posedge clk_in) begin
    if (ld_valid_in && ld_ready_out) begin
      mem[ld_addr_in] <= ld_data_in;
    end
  end
endmodule

// [rtl/sre_host.sv]
// Bus master end: runs current-address, random and sequential reads.
// Assumes one EEPROM on the link; SCL is divided down from clk_in.
`timescale 1ns/1ps
module sre_host #(
  parameter int QTR = sre_pkg::QTR_CYC,
  parameter logic [6:0] DEV_ADDR = sre_pkg::DEV_ADDR_DFLT
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  sre_if.host link,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [1:0] cmd_kind_in,
  input wire logic [7:0] cmd_addr_in,
  input wire logic [7:0] cmd_len_in,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic done_out,
  output logic nack_out
);
  sre_pkg::sre_host_st_e st_reg;
  logic [15:0] div_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [1:0] txk_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [7:0] addr_reg;
  logic [7:0] left_reg;
  logic scl_reg;
  logic oe_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic rd_valid_reg;
  logic [7:0] rd_data_reg;
  logic done_reg;
  logic nack_reg;
  logic tick;
  logic last_bit;
  logic accept;

  assign tick = (div_reg == 16'(QTR - 1));
  assign last_bit = (bit_reg == sre_pkg::ACK_SLOT);
  assign accept = cmd_valid_in && (st_reg == sre_pkg::SRE_H_IDLE);
  assign cmd_ready_out = (st_reg == sre_pkg::SRE_H_IDLE);

  // Each bit is four quarters: set SDA, raise SCL, hold, sample and drop SCL
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= sre_pkg::SRE_H_IDLE;
      div_reg <= 16'h0000;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      txk_reg <= 2'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      addr_reg <= 8'h00;
      left_reg <= 8'h00;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 8'h00;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      div_reg <= (tick || accept) ? 16'h0000 : div_reg + 16'h0001;
      if (accept) begin
        // Random read opens with the dummy write; others go straight to read.
        st_reg <= sre_pkg::SRE_H_START;
        q_reg <= 2'h0;
        addr_reg <= cmd_addr_in;
        left_reg <= (cmd_len_in == 8'h00) ? 8'h01 : cmd_len_in;
        txk_reg <= (cmd_kind_in == sre_pkg::KIND_RAND) ? 2'h0 : 2'h2;
        nack_reg <= 1'b0;
      end else if (tick && (st_reg != sre_pkg::SRE_H_IDLE)) begin
        q_reg <= q_reg + 2'h1;
        unique case (st_reg)
          sre_pkg::SRE_H_START: begin
            // Also serves as the repeated start.
            if (q_reg == 2'h0) begin
              scl_reg <= 1'b0;
              oe_reg <= 1'b0;
            end else if (q_reg == 2'h1) begin
              scl_reg <= 1'b1;
            end else if (q_reg == 2'h2) begin
              oe_reg <= 1'b1;
            end else begin
              scl_reg <= 1'b0;
              st_reg <= sre_pkg::SRE_H_TX;
              bit_reg <= 4'h0;
              tx_reg <= {DEV_ADDR, txk_reg[1]};
            end
          end
          sre_pkg::SRE_H_TX: begin
            if (q_reg == 2'h0) begin
              oe_reg <= !last_bit && !tx_reg[7];
            end else if (q_reg == 2'h1) begin
              scl_reg <= 1'b1;
            end else if (q_reg == 2'h3) begin
              scl_reg <= 1'b0;
              bit_reg <= last_bit ? 4'h0 : bit_reg + 4'h1;
              tx_reg <= {tx_reg[6:0], 1'b0};
              if (last_bit && sda_s2_reg) begin
                nack_reg <= 1'b1;
                st_reg <= sre_pkg::SRE_H_STOP;
              end else if (last_bit && (txk_reg == 2'h0)) begin
                // Word address only, no data byte.
                tx_reg <= addr_reg;
                txk_reg <= 2'h1;
              end else if (last_bit && (txk_reg == 2'h1)) begin
                txk_reg <= 2'h2;
                st_reg <= sre_pkg::SRE_H_START;
              end else if (last_bit) begin
                st_reg <= sre_pkg::SRE_H_RX;
              end
            end
          end
          sre_pkg::SRE_H_RX: begin
            if (q_reg == 2'h0) begin
              // Ack while more bytes are wanted, else leave it high.
              oe_reg <= last_bit && (left_reg != 8'h01);
            end else if (q_reg == 2'h1) begin
              scl_reg <= 1'b1;
            end else if (q_reg == 2'h3) begin
              scl_reg <= 1'b0;
              if (!last_bit) begin
                rx_reg <= {rx_reg[6:0], sda_s2_reg};
                bit_reg <= bit_reg + 4'h1;
              end else begin
                bit_reg <= 4'h0;
                rd_valid_reg <= 1'b1;
                rd_data_reg <= rx_reg;
                left_reg <= left_reg - 8'h01;
                if (left_reg == 8'h01) begin
                  st_reg <= sre_pkg::SRE_H_STOP;
                end
              end
            end
          end
          sre_pkg::SRE_H_STOP: begin
            if (q_reg == 2'h0) begin
              scl_reg <= 1'b0;
              oe_reg <= 1'b1;
            end else if (q_reg == 2'h1) begin
              scl_reg <= 1'b1;
            end else if (q_reg == 2'h2) begin
              oe_reg <= 1'b0;
            end else begin
              st_reg <= sre_pkg::SRE_H_IDLE;
              done_reg <= 1'b1;
            end
          end
          default: begin
            st_reg <= sre_pkg::SRE_H_IDLE;
          end
        endcase
      end
    end
  end

  assign link.scl = scl_reg;
  assign link.sda_host_oe = oe_reg;
  assign link.sda_host_o = 1'b0;
  assign rd_valid_out = rd_valid_reg;
  assign rd_data_out = rd_data_reg;
  assign done_out = done_reg;
  assign nack_out = nack_reg;
endmodule

// [verif/sre_link_chk_sva.sv]
// Concurrent checks on the two-wire link between the EEPROM end and the bus master end.
// Assumes SCL is far slower than clk_in, so every link edge is seen on clk_in samples.
`timescale 1ns/1ps
module sre_link_chk #(
  parameter logic [6:0] DEV_ADDR = sre_pkg::DEV_ADDR_DFLT
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe
);
  logic scl_reg;
  logic sda_reg;
  logic quiet_reg;
  logic rd_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] byte_reg;
  wire rise = scl & ~scl_reg;
  wire start_ev = scl & scl_reg & sda_reg & ~sda;
  wire stop_ev = scl & scl_reg & ~sda_reg & sda;
  wire hit = rise & (cnt_reg == 4'h8);
  wire match = (sh_reg[7:1] == DEV_ADDR);

  // Bit position is rebuilt from the wire alone, so it never trusts either end's state
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      quiet_reg <= 1'b1;
      rd_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      byte_reg <= 8'h00;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      if (start_ev || stop_ev) begin
        cnt_reg <= 4'h0;
        byte_reg <= 8'h00;
        rd_reg <= 1'b0;
        quiet_reg <= stop_ev;
      end else if (rise) begin
        cnt_reg <= (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
        byte_reg <= (cnt_reg == 4'h9) ? byte_reg + 8'h01 : byte_reg;
        sh_reg <= {sh_reg[6:0], sda};
        if (hit && byte_reg == 8'h00) begin
          rd_reg <= sh_reg[0];
          quiet_reg <= ~match;
        end else if (hit && rd_reg && sda) begin
          quiet_reg <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence ninth_s;
    hit;
  endsequence

  sequence stop_s;
    stop_ev;
  endsequence

  addr_ack_a: assert property (ninth_s ##0 (byte_reg == 8'h00) |-> sda_dev_oe == match)
    else $error("device address acknowledge wrong");
  wr_ack_a: assert property (ninth_s ##0 (byte_reg != 8'h00 && !rd_reg && !quiet_reg) |-> sda_dev_oe)
    else $error("word address not acknowledged");
  rd_release_a: assert property (ninth_s ##0 (byte_reg != 8'h00 && rd_reg) |-> !sda_dev_oe)
    else $error("device drives master acknowledge slot");
  host_rel_a: assert property (ninth_s ##0 (!rd_reg) |-> !sda_host_oe)
    else $error("master drives device acknowledge slot");
  quiet_dev_a: assert property (quiet_reg |-> !sda_dev_oe)
    else $error("device drives line while it should be released");
  ack_slot_a: assert property ($rose(sda_dev_oe) && !rd_reg |-> cnt_reg == 4'h8 && !scl)
    else $error("acknowledge outside ninth clock");
  oe_at_fall_a: assert property ($rose(sda_dev_oe) |-> $fell(scl))
    else $error("device output changes away from clock fall");
  data_stable_a: assert property (scl && scl_reg && cnt_reg >= 4'h2 |-> $stable(sda))
    else $error("data changes while clock high inside a byte");
  nack_stop_a: assert property (ninth_s ##0 (byte_reg != 8'h00 && rd_reg && sda) |-> ##[1:1000] stop_s)
    else $error("no stop after master nack");
endmodule

// [verif/tb_serial_eeprom_read_engine.sv]
// Testbench: EEPROM end and bus master end joined by the link, read bytes scoreboarded.
// Assumes the rtl files compile first; host runs with a short quarter period.
`timescale 1ns/1ps
module tb_serial_eeprom_read_engine;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_valid2 = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_len = 8'h01;
  logic ld_valid = 1'b0;
  logic [7:0] ld_addr = 8'h00;
  logic [7:0] ld_data = 8'h00;
  logic ld_ready, busy, cmd_ready, rd_valid, done, nack;
  logic cmd_ready2, rd_valid2, done2, nack2;
  logic [7:0] rd_data;
  logic [7:0] exp_b;
  logic [7:0] ctr = 8'h00;
  logic [7:0] mem [256];
  logic [7:0] exp_q [$];
  integer seed = 79038;
  int n_fail = 0;
  int cmp_count = 0;

  sre_if lnk();
  sre_if lnk2();
  sre_dev sre_dev_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(lnk), .ld_valid_in(ld_valid),
    .ld_addr_in(ld_addr), .ld_data_in(ld_data), .ld_ready_out(ld_ready), .busy_out(busy));
  sre_host #(.QTR(4)) sre_host_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(lnk),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_kind_in(cmd_kind),
    .cmd_addr_in(cmd_addr), .cmd_len_in(cmd_len), .rd_valid_out(rd_valid),
    .rd_data_out(rd_data), .done_out(done), .nack_out(nack));
  // Second pair: master aims at a foreign address, so the EEPROM must stay silent
  sre_dev sre_dev_nack_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(lnk2),
    .ld_valid_in(1'b0), .ld_addr_in(8'h00), .ld_data_in(8'h00), .ld_ready_out(), .busy_out());
  sre_host #(.QTR(4), .DEV_ADDR(sre_pkg::DEV_ADDR_DFLT + 7'h01)) sre_host_nack_i (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .link(lnk2), .cmd_valid_in(cmd_valid2),
    .cmd_ready_out(cmd_ready2), .cmd_kind_in(cmd_kind), .cmd_addr_in(cmd_addr),
    .cmd_len_in(cmd_len), .rd_valid_out(rd_valid2), .rd_data_out(), .done_out(done2),
    .nack_out(nack2));
  sre_link_chk #(.DEV_ADDR(sre_pkg::DEV_ADDR_DFLT)) sre_link_chk_i (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .scl(lnk.scl), .sda(lnk.sda), .sda_dev_o(lnk.sda_dev_o),
    .sda_dev_oe(lnk.sda_dev_oe), .sda_host_o(lnk.sda_host_o), .sda_host_oe(lnk.sda_host_oe));

  always #5 clk_in = ~clk_in;

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Expected bytes follow the bench's own copy of the word address counter
  task automatic run(input logic [1:0] kind, input logic [7:0] addr, input logic [7:0] len,
                     input logic alt);
    int t;
    if (kind == sre_pkg::KIND_RAND && !alt) ctr = addr;
    for (int k = 0; k < len && !alt; k++) begin
      exp_q.push_back(mem[ctr]);
      ctr = ctr + 8'h01;
    end
    cmd_kind <= kind;
    cmd_addr <= addr;
    cmd_len <= len;
    if (alt) cmd_valid2 <= 1'b1;
    else cmd_valid <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_in);
      t++;
    end while ((alt ? cmd_ready2 : cmd_ready) !== 1'b1 && t < 100);
    cmd_valid <= 1'b0;
    cmd_valid2 <= 1'b0;
    do begin
      @(posedge clk_in);
      t++;
    end while ((alt ? done2 : done) !== 1'b1 && t < 20000);
    chk1("done", 1'b1, alt ? done2 : done);
    chk1("nack", alt, alt ? nack2 : nack);
    repeat (4) @(posedge clk_in);
    chk1("busy", 1'b0, busy);
    chk8("bytes left", 8'h00, 8'(exp_q.size()));
    $display("test kind %0d addr %h len %0d done", kind, addr, len);
  endtask

  always @(posedge clk_in) begin
    if (rd_valid === 1'b1) begin
      exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      chk8("read byte", exp_b, rd_data);
    end
    if (rd_valid2 === 1'b1) chk1("stray byte", 1'b0, rd_valid2);
  end

  initial begin
    // A real falling edge, so flops clocked by link edges are cleared too
    arst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    chk1("load ready", 1'b1, ld_ready);
    chk1("host ready", 1'b1, cmd_ready);
    ld_valid <= 1'b1;
    for (int a = 0; a < 256; a++) begin
      mem[a] = 8'($random(seed));
      ld_addr <= 8'(a);
      ld_data <= mem[a];
      do @(posedge clk_in); while (ld_ready !== 1'b1);
    end
    ld_valid <= 1'b0;
    $display("test fill done");
    run(sre_pkg::KIND_CUR, 8'h00, 8'h02, 1'b0);
    run(sre_pkg::KIND_RAND, 8'hFD, 8'h01, 1'b0);
    repeat (500) @(posedge clk_in);
    run(sre_pkg::KIND_CUR, 8'h00, 8'h01, 1'b0);
    run(sre_pkg::KIND_CUR, 8'h00, 8'h05, 1'b0);
    for (int i = 0; i < 6; i++) begin
      run(2'(i), 8'($random(seed)), 8'(1 + {$random(seed)} % 12), 1'b0);
    end
    run(sre_pkg::KIND_RAND, 8'h10, 8'h01, 1'b1);
    give_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk_in);
    n_fail++;
    $display("mismatch watchdog expected finish seen timeout");
    give_verdict();
  end
endmodule
